// File: hw/aspr_pkg.sv
// Purpose: shared constants and types for the serial port block
// Assumes: one 250 MHz system clock, synchronous active-low reset
// Notes: receive timing works on a 16x oversampled tick
package aspr_pkg;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] MID_TICK = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hf;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP = 3'b100
  } aspr_state_t;
endpackage

// File: hw/aspr_tick_gen.sv
// Purpose: oversampled tick divider for the serial port
// Assumes: divisor of zero behaves as one
// Notes: tick is a one-cycle enable pulse
`timescale 1ns/100ps
module aspr_tick_gen (
  // clock and reset
  input wire logic sysClk,
  input wire logic rst_n,
  // divider control
  input wire logic [15:0] divisor,
  output logic tick
);
  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } aspr_tick_t;

  aspr_tick_t st;
  aspr_tick_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.count + 16'h0001 >= divisor) begin
      next_st.count = 16'h0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + 16'h0001;
    end
  end

  always_ff @(posedge sysClk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule

// File: hw/aspr_serial_port.sv
// Purpose: asynchronous character transmitter and receiver with rts/cts
// Assumes: rxLine, ctsIn and controls synchronous to sys_clk
// Notes: bit period is divisor * 16 system clocks
//
// How it works
// [R01] frame is start, eight data bits lsb first, optional parity, stop
// [R02] receiver times from start edge and samples every bit mid-period
// [R03] transmitter holds line high one full bit after data or parity
// [R04] idle transmitter keeps its line at mark level
// [R05] both ends share one bit rate; divisor sets it here
// [R06] with flow control, request-to-send rises while data waits
// [R07] with flow control, sending starts only while clear-to-send is high
// [R08] without flow control, sending ignores all control lines
// [R09] half duplex: no transmit start while a receive is in progress
// [R10] full duplex: transmit and receive run independently
// [R11] parity makes ones count odd or even; none sends no bit
// [R12] unread character overwritten by new one raises overrun
// [R13] low stop sample reports framing error
// [R14] bit period from programmable divider, receiver on oversampled tick
`timescale 1ns/100ps
module aspr_serial_port (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // configuration
  input wire logic [15:0] divisor,
  input wire logic [1:0] parityMode,
  input wire logic flowEnable,
  input wire logic halfDuplex,
  // transmit request
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  // receive data
  output logic [7:0] rxData,
  output logic rxAvail,
  input wire logic rxTake,
  output logic overrunErr,
  output logic framingErr,
  output logic parityErr,
  // line
  output logic txLine,
  input wire logic rxLine,
  output logic rtsOut,
  input wire logic ctsIn
);
  typedef struct packed {
    aspr_pkg::aspr_state_t txState;
    logic [3:0] txTick;
    logic [3:0] txBit;
    logic [7:0] txShift;
    logic txPar;
    logic txLine;
    logic txReady;
    logic [7:0] txHold;
    logic txPend;
    logic rts;
    aspr_pkg::aspr_state_t rxState;
    logic [3:0] rxTick;
    logic [3:0] rxBit;
    logic [7:0] rxShift;
    logic rxPar;
    logic rxPrev;
    logic [7:0] rxData;
    logic rxAvail;
    logic overrun;
    logic framing;
    logic parity;
  } aspr_port_t;

  aspr_port_t st;
  aspr_port_t next_st;
  logic tick;

  // oversampled tick from the programmable divider
  aspr_tick_gen u_aspr_tick_gen ( // [R14] [R05]
    .sysClk(sys_clk),
    .rst_n(rst_n),
    .divisor(divisor),
    .tick(tick)
  );

  // odd parity bit for a byte; even is its inverse
  function automatic logic parityBit(input logic [7:0] d,
                                     input logic [1:0] mode);
    parityBit = (mode == aspr_pkg::PAR_ODD) ? ~^d : ^d; // [R11]
  endfunction

  logic rxBusy;
  logic canSend;
  always_comb begin
    rxBusy = (st.rxState != aspr_pkg::ST_IDLE);
    canSend = (!flowEnable || ctsIn) // [R07] [R08]
            && !(halfDuplex && rxBusy); // [R09] [R10]
  end

  always_comb begin
    next_st = st;
    // ----------------------------------------
    // transmit side
    // ----------------------------------------
    if (txValid && st.txReady) begin
      next_st.txHold = txData;
      next_st.txPend = 1'b1;
      next_st.txReady = 1'b0;
    end
    next_st.rts = flowEnable && (st.txPend ||
                  st.txState != aspr_pkg::ST_IDLE); // [R06]
    if (tick) begin
      next_st.txTick = st.txTick + 4'h1;
      case (st.txState)
        aspr_pkg::ST_IDLE: begin
          next_st.txLine = 1'b1; // [R04]
          if (st.txPend && canSend && st.txTick == aspr_pkg::LAST_TICK) begin
            next_st.txState = aspr_pkg::ST_START;
            next_st.txShift = st.txHold;
            next_st.txPar = parityBit(st.txHold, parityMode);
            next_st.txPend = 1'b0;
            next_st.txReady = 1'b1;
            next_st.txLine = 1'b0; // [R01]
            next_st.txBit = 4'h0;
          end
        end
        aspr_pkg::ST_START: begin
          if (st.txTick == aspr_pkg::LAST_TICK) begin
            next_st.txState = aspr_pkg::ST_DATA;
            next_st.txLine = st.txShift[0]; // [R01]
            next_st.txShift = {1'b0, st.txShift[7:1]};
            next_st.txBit = 4'h1;
          end
        end
        aspr_pkg::ST_DATA: begin
          if (st.txTick == aspr_pkg::LAST_TICK) begin
            if (st.txBit == aspr_pkg::DATA_BITS) begin
              if (parityMode != aspr_pkg::PAR_NONE) begin
                next_st.txState = aspr_pkg::ST_PARITY;
                next_st.txLine = st.txPar; // [R11]
              end else begin
                next_st.txState = aspr_pkg::ST_STOP;
                next_st.txLine = 1'b1;
              end
            end else begin
              next_st.txLine = st.txShift[0];
              next_st.txShift = {1'b0, st.txShift[7:1]};
              next_st.txBit = st.txBit + 4'h1;
            end
          end
        end
        aspr_pkg::ST_PARITY: begin
          if (st.txTick == aspr_pkg::LAST_TICK) begin
            next_st.txState = aspr_pkg::ST_STOP;
            next_st.txLine = 1'b1;
          end
        end
        aspr_pkg::ST_STOP: begin
          // a full bit of mark before idle can start the next frame
          if (st.txTick == aspr_pkg::LAST_TICK) begin
            next_st.txState = aspr_pkg::ST_IDLE; // [R03]
          end
        end
        default: next_st.txState = aspr_pkg::ST_IDLE;
      endcase
    end
    // ----------------------------------------
    // receive side
    // ----------------------------------------
    if (rxTake) begin
      next_st.rxAvail = 1'b0;
    end
    if (tick) begin
      next_st.rxPrev = rxLine;
      next_st.rxTick = st.rxTick + 4'h1;
      case (st.rxState)
        aspr_pkg::ST_IDLE: begin
          if (st.rxPrev && !rxLine) begin
            next_st.rxState = aspr_pkg::ST_START; // [R02]
            next_st.rxTick = 4'h0;
          end
        end
        aspr_pkg::ST_START: begin
          if (st.rxTick == aspr_pkg::MID_TICK) begin
            next_st.rxTick = 4'h0;
            next_st.rxBit = 4'h0;
            // a glitch shorter than half a bit is dropped
            next_st.rxState = rxLine ? aspr_pkg::ST_IDLE
                                     : aspr_pkg::ST_DATA;
          end
        end
        aspr_pkg::ST_DATA: begin
          if (st.rxTick == aspr_pkg::LAST_TICK) begin // [R02]
            next_st.rxShift = {rxLine, st.rxShift[7:1]}; // [R01]
            next_st.rxBit = st.rxBit + 4'h1;
            if (st.rxBit == aspr_pkg::DATA_BITS - 4'h1) begin
              next_st.rxState = (parityMode != aspr_pkg::PAR_NONE)
                              ? aspr_pkg::ST_PARITY : aspr_pkg::ST_STOP;
            end
          end
        end
        aspr_pkg::ST_PARITY: begin
          if (st.rxTick == aspr_pkg::LAST_TICK) begin
            next_st.rxPar = rxLine;
            next_st.rxState = aspr_pkg::ST_STOP;
          end
        end
        aspr_pkg::ST_STOP: begin
          if (st.rxTick == aspr_pkg::LAST_TICK) begin
            next_st.rxState = aspr_pkg::ST_IDLE;
            next_st.rxData = st.rxShift;
            next_st.rxAvail = 1'b1;
            next_st.overrun = st.rxAvail && !rxTake; // [R12]
            next_st.framing = !rxLine; // [R13]
            next_st.parity = (parityMode != aspr_pkg::PAR_NONE) &&
              (st.rxPar != parityBit(st.rxShift, parityMode)); // [R11]
          end
        end
        default: next_st.rxState = aspr_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.txLine <= 1'b1;
      st.txReady <= 1'b1;
      st.rxPrev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign txLine = st.txLine;
  assign txReady = st.txReady;
  assign rtsOut = st.rts;
  assign rxData = st.rxData;
  assign rxAvail = st.rxAvail;
  assign overrunErr = st.overrun;
  assign framingErr = st.framing;
  assign parityErr = st.parity;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_IDLE_MARK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(st.txState) == aspr_pkg::ST_IDLE && st.txState ==
    aspr_pkg::ST_IDLE |-> txLine) else $error("idle line not mark"); // [R04]
  AST_START_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.txState == aspr_pkg::ST_START |-> !txLine)
    else $error("start bit not low"); // [R01]
  AST_STOP_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.txState == aspr_pkg::ST_STOP |-> txLine)
    else $error("stop bit not high"); // [R03]
  AST_CTS_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(st.txState == aspr_pkg::ST_START) |-> $past(!flowEnable || ctsIn))
    else $error("sent without clear-to-send"); // [R07]
  AST_HALF_DUPLEX: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(st.txState == aspr_pkg::ST_START) && $past(halfDuplex) |->
    $past(st.rxState) == aspr_pkg::ST_IDLE)
    else $error("transmit began during receive"); // [R09]
  AST_RTS_PEND: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.txPend && flowEnable |=> rtsOut)
    else $error("request-to-send missing"); // [R06]
  AST_NO_RTS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !flowEnable |=> !rtsOut) else $error("rts without flow control"); // [R08]
  AST_FRAMING: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tick && st.rxState == aspr_pkg::ST_STOP && st.rxTick ==
    aspr_pkg::LAST_TICK |=> framingErr == !$past(rxLine) && rxAvail)
    else $error("framing flag wrong"); // [R13]
  AST_OVERRUN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tick && st.rxState == aspr_pkg::ST_STOP && st.rxTick ==
    aspr_pkg::LAST_TICK && st.rxAvail && !rxTake |=> overrunErr)
    else $error("overrun not flagged"); // [R12]
endmodule

// File: tb/aspr_peer_model.sv
// Purpose: peer serial device facing the port
// Assumes: bit period is bitLen system clocks
// Notes: cts lags rts by four cycles, like a slow modem
`timescale 1ns/100ps
module aspr_peer_model (
  // clock
  input wire logic clk,
  // line
  input wire logic txLine,
  input wire logic rtsOut,
  output logic rxLine,
  output logic ctsIn
);
  int bitLen = 16;
  logic ctsAllow = 1'h0;
  logic [3:0] rtsHist = 4'h0;
  initial rxLine = 1'h1;
  always @(posedge clk) begin
    rtsHist <= {rtsHist[2:0], rtsOut};
  end
  assign ctsIn = ctsAllow && rtsHist[3];
  // ----
  // frame out
  // ----
  task automatic send(input logic [7:0] d, input logic [1:0] pm,
                      input logic bp, input logic bs);
    logic [10:0] f;
    int n;
    f = {~bs, ((pm == 2'h1) ? ~^d : ^d) ^ bp, d, 1'h0};
    n = (pm == 2'h0) ? 10 : 11;
    if (pm == 2'h0) begin
      f[9] = ~bs;
    end
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      rxLine = f[i];
      repeat (bitLen - 1) @(negedge clk);
    end
    @(negedge clk);
    rxLine = 1'h1;
  endtask
  // ----
  // frame in, sampled mid-bit
  // ----
  task automatic get(input logic hasPar, output logic [7:0] d,
                     output logic p, output logic s);
    int n;
    n = 0;
    while (txLine !== 1'h0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    repeat (bitLen / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bitLen) @(negedge clk);
      d[i] = txLine;
    end
    p = 1'h0;
    if (hasPar) begin
      repeat (bitLen) @(negedge clk);
      p = txLine;
    end
    repeat (bitLen) @(negedge clk);
    s = txLine;
  endtask
endmodule

// File: tb/tb_aspr_serial_port.sv
// Purpose: self-checking bench for the serial port
// Assumes: divisor 1, so one bit is 16 clocks; the last tTx case uses divisor 2, so 32 clocks
// Notes: inputs change on the falling edge, except ctsIn, which also changes on the rising edge
`timescale 1ns/100ps
module tb_aspr_serial_port;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [15:0] divisor = 16'h0001;
  logic [1:0] pm = 2'h0;
  logic flowEnable = 1'h0;
  logic halfDuplex = 1'h0;
  logic txValid = 1'h0;
  logic [7:0] txData = 8'h00;
  logic rxTake = 1'h0;
  logic txReady, rxAvail, overrunErr, framingErr, parityErr;
  logic txLine, rxLine, rtsOut, ctsIn;
  logic [7:0] rxData, d;
  logic p, s;
  int badCount = 0;
  int numChecks = 0;
  int lows;
  aspr_serial_port u_aspr_serial_port (.sys_clk(sys_clk),
    .rst_n(rst_n), .divisor(divisor), .parityMode(pm),
    .flowEnable(flowEnable), .halfDuplex(halfDuplex),
    .txValid(txValid), .txData(txData), .txReady(txReady),
    .rxData(rxData), .rxAvail(rxAvail), .rxTake(rxTake),
    .overrunErr(overrunErr), .framingErr(framingErr),
    .parityErr(parityErr), .txLine(txLine), .rxLine(rxLine),
    .rtsOut(rtsOut), .ctsIn(ctsIn));
  aspr_peer_model u_aspr_peer_model (.clk(sys_clk), .txLine(txLine),
    .rtsOut(rtsOut), .rxLine(rxLine), .ctsIn(ctsIn));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // ----
  // helpers
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic endOfTest();
    $display("checks %0d errors %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic put(input logic [7:0] v);
    int n;
    n = 0;
    @(negedge sys_clk);
    txValid = 1'h1;
    txData = v;
    // taken at the next rising edge that sees txReady high
    while (txReady !== 1'h1 && n < 5000) begin
      @(negedge sys_clk);
      n++;
    end
    check(txReady, 1'h1);
    @(negedge sys_clk);
    txValid = 1'h0;
  endtask
  task automatic quiet(input int n);
    lows = 0;
    repeat (n) begin
      @(negedge sys_clk);
      lows += (txLine !== 1'h1);
    end
  endtask
  // ----
  // scenarios
  // ----
  task automatic tTx();
    for (int k = 0; k < 4; k++) begin
      @(negedge sys_clk);
      pm = k[1:0] % 2'h3;
      divisor = (k == 3) ? 16'h0002 : 16'h0001;
      u_aspr_peer_model.bitLen = 16 * divisor;
      put(8'h2b + 8'h31 * k[7:0]);
      u_aspr_peer_model.get(pm != 2'h0, d, p, s);
      check(d, 8'h2b + 8'h31 * k[7:0]);
      check(p, (pm == 2'h1) ? ~^d : (pm == 2'h2) ? ^d : 1'h0);
      check(s, 1'h1);
      quiet(40);
      check(lows, 0);
    end
    divisor = 16'h0001;
    u_aspr_peer_model.bitLen = 16;
  endtask
  task automatic rxOne(input logic [7:0] v, input logic bp,
                       input logic bs, input logic ov, input logic tk);
    int n;
    n = 0;
    u_aspr_peer_model.send(v, pm, bp, bs);
    while (rxAvail !== 1'h1 && n < 64) begin
      @(negedge sys_clk);
      n++;
    end
    check(rxAvail, 1'h1);
    check(rxData, v);
    check(parityErr, bp);
    check(framingErr, bs);
    check(overrunErr, ov);
    if (tk) begin
      rxTake = 1'h1;
      @(negedge sys_clk);
      rxTake = 1'h0;
      @(negedge sys_clk);
      check(rxAvail, 1'h0);
    end
  endtask
  task automatic tFlow();
    flowEnable = 1'h1;
    put(8'h5a);
    quiet(48);
    check(lows, 0);
    check(rtsOut, 1'h1);
    u_aspr_peer_model.ctsAllow = 1'h1;
    u_aspr_peer_model.get(1'h1, d, p, s);
    check(d, 8'h5a);
    quiet(24);
    check(rtsOut, 1'h0);
    flowEnable = 1'h0;
    u_aspr_peer_model.ctsAllow = 1'h0;
    put(8'hc3);
    u_aspr_peer_model.get(1'h1, d, p, s);
    check(d, 8'hc3);
  endtask
  task automatic tDuplex();
    halfDuplex = 1'h1;
    fork
      rxOne(8'h6e, 1'h0, 1'h0, 1'h0, 1'h1);
      begin
        repeat (40) @(negedge sys_clk);
        put(8'h17);
        quiet(90);
        check(lows, 0);
        // wait here so the start bit cannot slip past the peer
        u_aspr_peer_model.get(1'h1, d, p, s);
      end
    join
    check(d, 8'h17);
    halfDuplex = 1'h0;
    fork
      rxOne(8'h93, 1'h0, 1'h0, 1'h0, 1'h1);
      begin
        put(8'h4c);
        u_aspr_peer_model.get(1'h1, d, p, s);
      end
      begin
        // the start bit must go out while the receive is still running
        quiet(40);
        check(lows != 0, 1'h1);
      end
    join
    check(d, 8'h4c);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (3) @(negedge sys_clk);
    rst_n = 1'h1;
    check(txLine, 1'h1);
    check(txReady, 1'h1);
    tTx();
    rxOne(8'h41, 1'h0, 1'h0, 1'h0, 1'h1);
    pm = 2'h1;
    rxOne(8'h15, 1'h1, 1'h0, 1'h0, 1'h1);
    pm = 2'h2;
    rxOne(8'h39, 1'h0, 1'h1, 1'h0, 1'h0);
    rxOne(8'h02, 1'h0, 1'h0, 1'h1, 1'h1);
    tFlow();
    tDuplex();
    endOfTest();
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    badCount++;
    endOfTest();
  end
endmodule
